// ### core/uartc_pkg.sv
`default_nettype none
package uartc_pkg;
	// Register offsets on the 3-bit host port
	localparam logic [2:0] ADR_EXT0 = 3'h0;
	localparam logic [2:0] ADR_MASK = 3'h1;
	localparam logic [2:0] ADR_IDENT = 3'h2;
	localparam logic [2:0] ADR_LFC = 3'h3;
	localparam logic [2:0] ADR_MOC = 3'h4;
	localparam logic [2:0] ADR_LSTAT = 3'h5;
	localparam logic [2:0] ADR_MSTAT = 3'h6;
	// Identification codes, bits 3..0
	localparam logic [3:0] ID_NONE = 4'h1;
	localparam logic [3:0] ID_LINE = 4'h6;
	localparam logic [3:0] ID_RXDATA = 4'h4;
	localparam logic [3:0] ID_TIMEOUT = 4'hC;
	localparam logic [3:0] ID_THRE = 4'h2;
	localparam logic [3:0] ID_MODEM = 4'h0;
	// Line format field positions
	localparam int LFC_STOP = 2;
	localparam int LFC_PEN = 3;
	localparam int LFC_EVEN = 4;
	localparam int LFC_STICK = 5;
	localparam int LFC_BRK = 6;
	localparam int LFC_DLAB = 7;
	// Modem control field positions
	localparam int MOC_LOOP = 4;
	// Interrupt mask field positions
	localparam int MSK_RX = 0;
	localparam int MSK_TX = 1;
	localparam int MSK_LS = 2;
	localparam int MSK_MS = 3;
	// Values after reset
	localparam logic [7:0] LFC_RST = 8'h00;
	localparam logic [4:0] MOC_RST = 5'h00;
	localparam logic [3:0] MSK_RST = 4'h0;
	// Interrupt sources in descending priority
	typedef enum logic [2:0] {
		SRC_NONE = 3'b000,
		SRC_LINE = 3'b001,
		SRC_RXDATA = 3'b010,
		SRC_TIMEOUT = 3'b011,
		SRC_THRE = 3'b100,
		SRC_MODEM = 3'b101
	} uartc_src_t;
endpackage
`default_nettype wire

// ### core/uartc_parity.sv
`timescale 1ns/1ps
`default_nettype none
// Parity bit for a character of 5 to 8 bits
module uartc_parity
	import uartc_pkg::*;
#(
	parameter int MAX_BITS = 8
) (
	input wire logic [MAX_BITS-1:0] data,
	input wire logic [1:0] len_sel,
	input wire logic even,
	input wire logic stick,
	output logic par_bit
);
	// Only 5..8 bit characters are served
	if (MAX_BITS != 8) begin : g_chk
		$error("uartc_parity: MAX_BITS must be 8");
	end
	logic [MAX_BITS-1:0] mask; // Bits inside the character
	logic ones; // XOR of the used bits
	// Mask off the bits beyond the chosen length
	always_comb begin
		mask = {MAX_BITS{1'b1}} >> (2'd3 - len_sel);
		ones = ^(data & mask);
		// Stick parity is 1 for odd setting, 0 for even
		if (stick) begin
			par_bit = ~even; // see RL8
		end else if (even) begin
			par_bit = ones; // see RL7
		end else begin
			par_bit = ~ones; // see RL7
		end
	end
endmodule // uartc_parity
`default_nettype wire

// ### core/uartc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RL1 - Ident read clears only highest pending source
// RL2 - Ident codes 6,4,C,2,0; 1 means none
// RL3 - Ident bit 0 low while pending
// RL4 - Ident bits 7:6 show FIFO enable
// RL5 - Line format bits 1:0 pick length
// RL6 - Bit 2 selects longer stop time
// RL7 - Bit 3 parity on, bit 4 even
// RL8 - Bit 5 forces parity to fixed value
// RL9 - Bit 6 holds transmit line low; in loop-back TX stays high and only the looped receiver line goes low
// RL10 - Bit 7 opens divisor latch access
// RL11 - Modem control bits drive low-active outputs
// RL12 - Bit 4 loop-back, bits 7:5 zero
// RL13 - Line state bit 0 data ready
// RL14 - Overrun when character lands on full FIFO
// RL15 - Parity and framing errors of top character
// RL16 - Break sets flag, one break character stored
// RL17 - Holding empty flag, raises transmit interrupt
// RL18 - Transmitter fully empty flag
// RL19 - Bit 7 marks errors anywhere in FIFO
// RL20 - Modem input changes set delta bits
// RL21 - Ring delta only on trailing edge
// RL22 - Modem status shows inputs or loop bits
// RL23 - Divisors reachable only with bit 7 set
// RL24 - Receive interrupt follows trigger level
// RL25 - Sources reported only when mask enabled
// RL26 - Loop-back routes transmitter to receiver
// RL27 - Interrupt output follows pending state
module uartc_ctrl
	import uartc_pkg::*;
#(
	parameter int DATA_W = 8
) (
	input wire logic CLK_SYS,
	input wire logic RSTN,
	input wire logic [2:0] ADDR, // Register offset
	input wire logic [DATA_W-1:0] WDATA, // Write data
	input wire logic WR, // Write strobe
	input wire logic RD, // Read strobe
	output logic [DATA_W-1:0] RDATA, // Read data, cycle after RD
	output logic INT, // Interrupt request, high
	output logic EXT_WR, // Holding or divisor write
	output logic EXT_RD, // Holding or divisor read
	output logic EXT_DIV, // Divisor latch selected
	input wire logic [DATA_W-1:0] EXT_RDATA, // Holding or divisor data
	input wire logic FIFO_EN, // FIFOs enabled
	input wire logic RX_DONE, // Receiver finished a character
	input wire logic [DATA_W-1:0] RX_DATA, // Its data bits
	input wire logic RX_PAR, // Its received parity bit
	input wire logic RX_FE, // Its stop bit was missing
	input wire logic RX_BRK, // It was a break
	output logic RX_PUSH, // Store character into FIFO
	output logic RX_PUSH_PE, // Parity error flag to store
	input wire logic RX_EMPTY, // Receive FIFO empty
	input wire logic RX_FULL, // Receive FIFO full
	input wire logic RX_TRIG, // FIFO at trigger level
	input wire logic RX_TIMEOUT, // Receive timeout pending
	input wire logic RX_TOP_PE, // Top character parity error
	input wire logic RX_TOP_FE, // Top character framing error
	input wire logic RX_TOP_BI, // Top character break
	input wire logic RX_ERR_ANY, // Any FIFO character in error
	input wire logic TX_HOLD_EMPTY, // Holding register or FIFO empty
	input wire logic TX_SHIFT_EMPTY, // Shift register empty
	input wire logic [DATA_W-1:0] TX_PDATA, // Character being sent
	output logic TX_PAR_BIT, // Parity bit to send
	input wire logic TX_SER, // Transmitter serial output
	output logic TX, // Serial line out
	input wire logic RX, // Serial line in
	output logic RX_SER, // Serial input to the receiver
	output logic [1:0] WORD_LEN, // 0..3 = 5..8 bits
	output logic STOP_LONG, // Stop time beyond one bit
	output logic STOP_HALF, // Stop time of one and a half
	output logic PAR_EN, // Parity on
	input wire logic CTS_N, // Clear to send
	input wire logic DSR_N, // Set ready
	input wire logic RING_INDICATOR_N, // Ring
	input wire logic CARRIER_DETECT_N, // Carrier
	output logic TERMINAL_READY_N, // Terminal ready
	output logic SEND_REQUEST_N, // Request to send
	output logic USER_OUT1_N, // User output 1
	output logic USER_OUT2_N // User output 2
);
	// The register file holds 8-bit registers only
	if (DATA_W != 8) begin : g_chk
		$error("uartc_ctrl: DATA_W must be 8");
	end

	logic [3:0] mask_q; // Interrupt mask
	logic [7:0] lfc_q; // Line format control
	logic [4:0] moc_q; // Modem output control
	logic ovr_q; // Overrun flag
	logic ls_int_q; // Line status interrupt latch
	logic thre_int_q; // Holding-empty interrupt latch
	logic thre_prev_q; // Holding-empty level last cycle
	logic [3:0] msd_q; // Modem change bits
	logic [3:0] mst_q; // Modem status last cycle
	logic mst_ok_q; // mst_q holds a real sample
	logic brk_hold_q; // A break character was stored
	logic [7:0] rdata_q; // Read data
	logic int_q; // Interrupt output
	logic tx_q; // Serial line out
	logic rxs_q; // Receiver serial input
	logic [3:0] mstat; // Modem status now
	logic [7:0] lstat; // Line status now
	logic rx_lvl; // Receive data source level
	logic [4:0] pend; // Enabled sources, see uartc_src_t
	uartc_src_t src; // Highest pending source
	logic [3:0] id; // Its code
	logic rd_ident; // Ident read this cycle
	logic rd_lstat; // Line status read
	logic rd_mstat; // Modem status read
	logic ext_sel; // Offset reaches outside logic
	logic loop; // Loop-back mode
	logic rx_pe; // Parity check result
	logic rx_line; // Receiver line before register
	logic rx_is_brk_dup; // Repeated break character
	logic [3:0] msd_set; // Modem changes this cycle
	logic ls_set; // New line error this cycle
	logic thre_set; // Holding-empty event this cycle

	// Decode strobes
	assign rd_ident = RD && ADDR == ADR_IDENT;
	assign rd_lstat = RD && ADDR == ADR_LSTAT;
	assign rd_mstat = RD && ADDR == ADR_MSTAT;
	assign ext_sel = ADDR == ADR_EXT0 || (ADDR == ADR_MASK && lfc_q[LFC_DLAB]); // see RL23
	assign EXT_WR = WR && ext_sel;
	assign EXT_RD = RD && ext_sel;
	assign EXT_DIV = lfc_q[LFC_DLAB]; // see RL10
	assign loop = moc_q[MOC_LOOP];

	// Format outputs to the transmitter and receiver
	assign WORD_LEN = lfc_q[1:0]; // see RL5
	assign STOP_LONG = lfc_q[LFC_STOP]; // see RL6
	assign STOP_HALF = lfc_q[LFC_STOP] && lfc_q[1:0] == 2'h0; // see RL6
	assign PAR_EN = lfc_q[LFC_PEN]; // see RL7

	// Modem outputs, bit 1 pulls the pin low
	assign TERMINAL_READY_N = ~moc_q[0]; // see RL11
	assign SEND_REQUEST_N = ~moc_q[1]; // see RL11
	assign USER_OUT1_N = ~moc_q[2]; // see RL11
	assign USER_OUT2_N = ~moc_q[3]; // see RL11

	// Parity for the character leaving
	uartc_parity #(.MAX_BITS(8)) u_tx_par (
		.data(TX_PDATA),
		.len_sel(lfc_q[1:0]),
		.even(lfc_q[LFC_EVEN]),
		.stick(lfc_q[LFC_STICK]),
		.par_bit(TX_PAR_BIT)
	);

	logic rx_exp; // Expected parity of arriving character
	// Parity for the character arriving
	uartc_parity #(.MAX_BITS(8)) u_rx_par (
		.data(RX_DATA),
		.len_sel(lfc_q[1:0]),
		.even(lfc_q[LFC_EVEN]),
		.stick(lfc_q[LFC_STICK]),
		.par_bit(rx_exp)
	);
	assign rx_pe = lfc_q[LFC_PEN] && (rx_exp != RX_PAR); // see RL7

	// Receive path: overrun and single break character
	assign rx_is_brk_dup = RX_BRK && brk_hold_q; // see RL16
	assign RX_PUSH = RX_DONE && !RX_FULL && !rx_is_brk_dup; // see RL14
	assign RX_PUSH_PE = rx_pe; // see RL15
	assign ls_set = (RX_DONE && RX_FULL) || (RX_PUSH && (rx_pe || RX_FE || RX_BRK));

	// Line status word
	always_comb begin
		lstat[0] = ~RX_EMPTY; // see RL13
		lstat[1] = ovr_q; // see RL14
		lstat[2] = RX_TOP_PE && !RX_EMPTY; // see RL15
		lstat[3] = RX_TOP_FE && !RX_EMPTY; // see RL15
		lstat[4] = RX_TOP_BI && !RX_EMPTY; // see RL16
		lstat[5] = TX_HOLD_EMPTY; // see RL17
		lstat[6] = TX_HOLD_EMPTY && TX_SHIFT_EMPTY; // see RL18
		lstat[7] = FIFO_EN && RX_ERR_ANY; // see RL19
	end

	// Modem status: bits are cts, dsr, ring, carrier
	always_comb begin
		if (loop) begin
			mstat = {moc_q[3], moc_q[2], moc_q[0], moc_q[1]}; // see RL22
		end else begin
			mstat = ~{CARRIER_DETECT_N, RING_INDICATOR_N, DSR_N, CTS_N}; // see RL22
		end
		// Ring change only when the ring input ends
		msd_set[0] = mst_ok_q && mst_q[0] != mstat[0]; // see RL20
		msd_set[1] = mst_ok_q && mst_q[1] != mstat[1]; // see RL20
		msd_set[2] = mst_ok_q && mst_q[2] && !mstat[2]; // see RL21
		msd_set[3] = mst_ok_q && mst_q[3] != mstat[3]; // see RL20
	end

	// Receive data source: trigger level in FIFO mode
	assign rx_lvl = FIFO_EN ? RX_TRIG : !RX_EMPTY; // see RL24

	// Enabled sources and priority encode
	always_comb begin
		pend[0] = mask_q[MSK_LS] && ls_int_q; // see RL25
		pend[1] = mask_q[MSK_RX] && rx_lvl; // see RL25
		pend[2] = mask_q[MSK_RX] && FIFO_EN && RX_TIMEOUT; // see RL25
		pend[3] = mask_q[MSK_TX] && thre_int_q; // see RL25
		pend[4] = mask_q[MSK_MS] && |msd_q; // see RL25
		// Highest priority first
		if (pend[0]) begin
			src = SRC_LINE; // see RL2
		end else if (pend[1]) begin
			src = SRC_RXDATA;
		end else if (pend[2]) begin
			src = SRC_TIMEOUT;
		end else if (pend[3]) begin
			src = SRC_THRE;
		end else if (pend[4]) begin
			src = SRC_MODEM;
		end else begin
			src = SRC_NONE; // see RL3
		end
		// Source to code
		unique case (src)
			SRC_LINE: id = ID_LINE;
			SRC_RXDATA: id = ID_RXDATA;
			SRC_TIMEOUT: id = ID_TIMEOUT;
			SRC_THRE: id = ID_THRE;
			SRC_MODEM: id = ID_MODEM;
			SRC_NONE: id = ID_NONE;
			default: id = ID_NONE;
		endcase
	end

	// Holding-empty event: level rises, or mask bit opens
	assign thre_set = (TX_HOLD_EMPTY && !thre_prev_q) ||
		(WR && ADDR == ADR_MASK && !lfc_q[LFC_DLAB] && WDATA[MSK_TX] && !mask_q[MSK_TX] && TX_HOLD_EMPTY);

	// Software-written registers
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			mask_q <= MSK_RST;
			lfc_q <= LFC_RST;
			moc_q <= MOC_RST;
		end else if (WR) begin
			// Divisor access replaces the mask at its offset
			if (ADDR == ADR_MASK && !lfc_q[LFC_DLAB]) begin
				mask_q <= WDATA[3:0];
			end
			if (ADDR == ADR_LFC) begin
				lfc_q <= WDATA;
			end
			if (ADDR == ADR_MOC) begin
				moc_q <= WDATA[4:0]; // see RL12
			end
		end
	end

	// Overrun and line interrupt; set wins over clear
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			ovr_q <= 1'b0;
			ls_int_q <= 1'b0;
		end else begin
			if (RX_DONE && RX_FULL) begin
				ovr_q <= 1'b1; // see RL14
			end else if (rd_lstat) begin
				ovr_q <= 1'b0;
			end
			if (ls_set) begin
				ls_int_q <= 1'b1;
			end else if (rd_lstat || (rd_ident && src == SRC_LINE)) begin
				ls_int_q <= 1'b0; // see RL1
			end
		end
	end

	// Break suppression until the line returns high
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			brk_hold_q <= 1'b0;
		end else if (RX_PUSH && RX_BRK) begin
			brk_hold_q <= 1'b1; // see RL16
		end else if (rxs_q) begin
			brk_hold_q <= 1'b0;
		end
	end

	// Holding-empty interrupt latch
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			thre_int_q <= 1'b0;
			thre_prev_q <= 1'b1; // Idle level of an empty transmitter, no false edge
		end else begin
			thre_prev_q <= TX_HOLD_EMPTY;
			if (thre_set) begin
				thre_int_q <= 1'b1; // see RL17
			end else if ((rd_ident && src == SRC_THRE) || (EXT_WR && !lfc_q[LFC_DLAB])) begin
				thre_int_q <= 1'b0; // see RL1
			end
		end
	end

	// Modem change bits; first sample after reset sets none
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			msd_q <= 4'h0;
			mst_q <= 4'h0;
			mst_ok_q <= 1'b0;
		end else begin
			mst_q <= mstat;
			mst_ok_q <= 1'b1;
			if (rd_mstat || (rd_ident && src == SRC_MODEM)) begin
				msd_q <= msd_set; // see RL20
			end else begin
				msd_q <= msd_q | msd_set;
			end
		end
	end

	// Read data, valid the cycle after the strobe only
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			rdata_q <= 8'h00;
		end else if (!RD) begin
			rdata_q <= 8'h00;
		end else if (ext_sel) begin
			rdata_q <= EXT_RDATA;
		end else begin
			unique case (ADDR)
				ADR_MASK: rdata_q <= {4'h0, mask_q};
				ADR_IDENT: rdata_q <= {FIFO_EN, FIFO_EN, 2'h0, id}; // see RL4
				ADR_LFC: rdata_q <= lfc_q;
				ADR_MOC: rdata_q <= {3'h0, moc_q}; // see RL12
				ADR_LSTAT: rdata_q <= lstat;
				ADR_MSTAT: rdata_q <= {mstat, msd_q};
				default: rdata_q <= 8'h00;
			endcase
		end
	end
	assign RDATA = rdata_q;

	// Interrupt output and serial lines
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			int_q <= 1'b0;
			tx_q <= 1'b1;
			rxs_q <= 1'b1;
		end else begin
			int_q <= src != SRC_NONE; // see RL27
			tx_q <= loop ? 1'b1 : (TX_SER && !lfc_q[LFC_BRK]); // see RL9
			rxs_q <= rx_line; // see RL26
		end
	end
	assign rx_line = loop ? (TX_SER && !lfc_q[LFC_BRK]) : RX; // see RL26
	assign INT = int_q;
	assign TX = tx_q;
	assign RX_SER = rxs_q;

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RSTN);

	sequence s_ident_rd;
		RD && ADDR == ADR_IDENT;
	endsequence
	sequence s_lstat_rd;
		RD && ADDR == ADR_LSTAT;
	endsequence

	AST_ID_NONE: assert property (s_ident_rd and !(|pend) |=> RDATA[3:0] == ID_NONE) // see RL3
		else $error("ident not 1 with nothing pending");
	AST_LINE_FIRST: assert property (s_ident_rd and pend[0] |=> RDATA[3:0] == ID_LINE) // see RL2
		else $error("line status not given top priority");
	AST_ID_CLR: assert property (s_ident_rd and src == SRC_LINE && !ls_set |=> !ls_int_q) // see RL1
		else $error("line interrupt not cleared by ident read");
	AST_FIFO_BITS: assert property (s_ident_rd |=> RDATA[7:6] == {2{$past(FIFO_EN)}} && RDATA[5:4] == 2'h0) // see RL4
		else $error("ident bits 7:4 wrong");
	AST_BREAK: assert property (lfc_q[LFC_BRK] && !loop |=> !TX) // see RL9
		else $error("break does not hold line low");
	AST_LOOP_TX: assert property (loop [*2] |-> TX) // see RL26
		else $error("line not idle in loop-back");
	AST_OVR: assert property (RX_DONE && RX_FULL |-> !RX_PUSH ##1 ovr_q) // see RL14
		else $error("overrun mishandled");
	AST_MS_LOOP: assert property (rd_mstat && loop |=> RDATA[7:4] == {$past(moc_q[3]), $past(moc_q[2]),
		$past(moc_q[0]), $past(moc_q[1])}) // see RL22
		else $error("loop-back modem status wrong");
	AST_RING: assert property ($rose(msd_q[2]) |-> !mst_q[2] && $past(mst_q[2])) // see RL21
		else $error("ring change on wrong edge");
	AST_LSTAT: assert property (s_lstat_rd |=> RDATA[0] == !$past(RX_EMPTY) &&
		RDATA[6] == $past(TX_HOLD_EMPTY && TX_SHIFT_EMPTY)) // see RL13
		else $error("line status ready or empty wrong");
	AST_INT: assert property (pend[3] ##1 pend[3] |-> INT) // see RL27
		else $error("interrupt output not raised");
endmodule // uartc_ctrl
`default_nettype wire

// ### dv/uartc_modem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Remote modem and line partner
module uartc_modem_model (
	input wire logic clk_sys, // System clock
	input wire logic rstn, // Async reset, low
	input wire logic tx, // Line from the block
	input wire logic [3:0] req, // Asserted carrier, ring, set-ready, clear-to-send
	output logic cts_n, // Clear to send, low-active
	output logic dsr_n, // Set ready, low-active
	output logic ring_indicator_n, // Ring, low-active
	output logic carrier_detect_n, // Carrier, low-active
	output logic rx // Line back to the block
);
	// Status lines follow requests one cycle late; the line is turned round at the far end
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			{carrier_detect_n, ring_indicator_n, dsr_n, cts_n} <= 4'hF;
			rx <= 1'b1; // Idle line is high
		end else begin
			{carrier_detect_n, ring_indicator_n, dsr_n, cts_n} <= ~req;
			rx <= tx;
		end
	end
endmodule // uartc_modem_model
`default_nettype wire

// ### dv/tb_uart_line_modem_status_control.sv
`timescale 1ns/1ps
`default_nettype none
// Bench for the control and status block
module tb_uart_line_modem_status_control;
	import uartc_pkg::*;
	logic clk_sys = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0; // Clock, reset, strobes
	logic [2:0] addr = 3'h0; // Register offset
	logic [7:0] wdata = 8'h00, ext_rdata = 8'h5A, rx_data = 8'h00, tx_pdata = 8'h00; // Data buses
	logic fifo_en = 1'b0, rx_done = 1'b0, rx_par = 1'b0, rx_fe = 1'b0, rx_brk = 1'b0; // Receiver side
	logic rx_empty = 1'b1, rx_full = 1'b0, rx_trig = 1'b0, rx_tmo = 1'b0, err_any = 1'b0; // FIFO state
	logic top_pe = 1'b0, top_fe = 1'b0, top_bi = 1'b0, hold_empty = 1'b1, shift_empty = 1'b1, tx_ser = 1'b1;
	logic [7:0] rdata, v; // Read data and last read value
	logic intr, ext_wr, ext_rd, ext_div, rx_push, rx_push_pe, tx_par_bit, tx, rx, rx_ser; // Outputs
	logic stop_long, stop_half, par_en, cts_n, dsr_n, ring_indicator_n, carrier_detect_n; // Outputs
	logic dtr_n, rts_n, user_out1_n, user_out2_n; // Modem outputs
	logic [1:0] word_len; // Length field
	logic [3:0] req = 4'h0; // Requests to the modem
	int fail_count = 0, tests_run = 0; // Counters
	// Free-running clock
	always #50 clk_sys = ~clk_sys;
	uartc_ctrl dut (.CLK_SYS(clk_sys), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .INT(intr), .EXT_WR(ext_wr), .EXT_RD(ext_rd), .EXT_DIV(ext_div),
		.EXT_RDATA(ext_rdata), .FIFO_EN(fifo_en), .RX_DONE(rx_done), .RX_DATA(rx_data), .RX_PAR(rx_par),
		.RX_FE(rx_fe), .RX_BRK(rx_brk), .RX_PUSH(rx_push), .RX_PUSH_PE(rx_push_pe), .RX_EMPTY(rx_empty),
		.RX_FULL(rx_full), .RX_TRIG(rx_trig), .RX_TIMEOUT(rx_tmo), .RX_TOP_PE(top_pe), .RX_TOP_FE(top_fe),
		.RX_TOP_BI(top_bi), .RX_ERR_ANY(err_any), .TX_HOLD_EMPTY(hold_empty), .TX_SHIFT_EMPTY(shift_empty),
		.TX_PDATA(tx_pdata), .TX_PAR_BIT(tx_par_bit), .TX_SER(tx_ser), .TX(tx), .RX(rx), .RX_SER(rx_ser),
		.WORD_LEN(word_len), .STOP_LONG(stop_long), .STOP_HALF(stop_half), .PAR_EN(par_en),
		.CTS_N(cts_n), .DSR_N(dsr_n), .RING_INDICATOR_N(ring_indicator_n), .CARRIER_DETECT_N(carrier_detect_n),
		.TERMINAL_READY_N(dtr_n), .SEND_REQUEST_N(rts_n), .USER_OUT1_N(user_out1_n), .USER_OUT2_N(user_out2_n));
	uartc_modem_model far (.clk_sys(clk_sys), .rstn(rstn), .tx(tx), .req(req), .cts_n(cts_n),
		.dsr_n(dsr_n), .ring_indicator_n(ring_indicator_n), .carrier_detect_n(carrier_detect_n), .rx(rx));
	// Compare and count
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// One-cycle register write
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
		#1;
	endtask
	// Read, data taken in the cycle after the strobe
	task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		v = rdata;
		chk(v, exp);
	endtask
	// Let cycles pass
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// Values after reset
	task automatic t_reset();
		rd_chk(ADR_IDENT, 8'h01);
		rd_chk(ADR_LFC, 8'h00);
		rd_chk(ADR_MOC, 8'h00);
		chk({3'h0, tx, dtr_n, rts_n, user_out1_n, user_out2_n}, 8'h1F);
		rd_chk(ADR_LSTAT, 8'h60);
		rd_chk(ADR_MSTAT, 8'h00);
	endtask
	// Length, stop time and parity selection
	task automatic t_format();
		for (int i = 0; i < 4; i++) begin
			wr_reg(ADR_LFC, 8'h08 | i[7:0]);
			chk({6'h0, word_len}, i[7:0]);
			chk({7'h0, par_en}, 8'h01);
			rd_chk(ADR_LFC, 8'h08 | i[7:0]);
		end
		wr_reg(ADR_LFC, 8'h04);
		chk({6'h0, stop_long, stop_half}, 8'h03);
		wr_reg(ADR_LFC, 8'h07);
		chk({6'h0, stop_long, stop_half}, 8'h02);
		wr_reg(ADR_LFC, 8'h03);
		chk({6'h0, stop_long, stop_half}, 8'h00);
		@(posedge clk_sys);
		tx_pdata <= 8'h01;
		wr_reg(ADR_LFC, 8'h0B);
		chk({7'h0, tx_par_bit}, 8'h00);
		wr_reg(ADR_LFC, 8'h1B);
		chk({7'h0, tx_par_bit}, 8'h01);
		wr_reg(ADR_LFC, 8'h2B);
		chk({7'h0, tx_par_bit}, 8'h01);
		wr_reg(ADR_LFC, 8'h3B);
		chk({7'h0, tx_par_bit}, 8'h00);
	endtask
	// Break holds the line low until cleared
	task automatic t_break();
		wr_reg(ADR_LFC, 8'h40);
		idle(6);
		chk({7'h0, tx}, 8'h00);
		wr_reg(ADR_LFC, 8'h00);
		idle(2);
		chk({7'h0, tx}, 8'h01);
	endtask
	// Divisor access hides the mask; unmapped offset reads zero
	task automatic t_divisor();
		wr_reg(ADR_LFC, 8'h80);
		chk({7'h0, ext_div}, 8'h01);
		@(posedge clk_sys);
		addr <= ADR_MASK;
		wdata <= 8'h0F;
		wr <= 1'b1;
		#1;
		chk({6'h0, ext_wr, ext_rd}, 8'h02);
		@(posedge clk_sys);
		wr <= 1'b0;
		rd_chk(ADR_MASK, 8'h5A);
		wr_reg(ADR_LFC, 8'h00);
		chk({7'h0, ext_div}, 8'h00);
		rd_chk(ADR_MASK, 8'h00);
		rd_chk(ADR_EXT0, 8'h5A);
		rd_chk(3'h7, 8'h00);
	endtask
	// Every modem output pattern, upper bits written as ones
	task automatic t_modem_out();
		for (int i = 0; i < 16; i++) begin
			wr_reg(ADR_MOC, 8'hE0 | i[7:0]);
			chk({4'h0, user_out2_n, user_out1_n, rts_n, dtr_n}, {4'h0, ~i[3:0]});
			rd_chk(ADR_MOC, {4'h0, i[3:0]});
		end
	endtask
	// Loop-back routes the transmitter inward and mirrors control bits
	task automatic t_loop();
		wr_reg(ADR_MOC, 8'h1A);
		@(posedge clk_sys);
		tx_ser <= 1'b0;
		idle(3);
		chk({6'h0, tx, rx_ser}, 8'h02);
		rd_chk(ADR_MSTAT, 8'h99);
		chk({4'h0, v[7:4]}, 8'h09);
		@(posedge clk_sys);
		tx_ser <= 1'b1;
		wr_reg(ADR_MOC, 8'h00);
		rd_chk(ADR_MSTAT, 8'h09);
	endtask
	// Input changes, ring trailing edge and the modem interrupt
	task automatic t_modem_in();
		wr_reg(ADR_MASK, 8'h08);
		@(posedge clk_sys);
		req <= 4'h8;
		idle(4);
		chk({7'h0, intr}, 8'h01);
		rd_chk(ADR_IDENT, 8'h00);
		rd_chk(ADR_MSTAT, 8'h80);
		@(posedge clk_sys);
		req <= 4'hC;
		idle(4);
		rd_chk(ADR_MSTAT, 8'hC0);
		@(posedge clk_sys);
		req <= 4'h8;
		idle(4);
		rd_chk(ADR_MSTAT, 8'h84);
		@(posedge clk_sys);
		req <= 4'hB;
		idle(4);
		rd_chk(ADR_MSTAT, 8'hB3);
		rd_chk(ADR_MSTAT, 8'hB0);
		@(posedge clk_sys);
		req <= 4'h0;
		idle(4);
		rd_chk(ADR_MSTAT, 8'h0B);
		wr_reg(ADR_MASK, 8'h00);
		idle(3);
		chk({7'h0, intr}, 8'h00);
	endtask
	// Overrun on a full FIFO, then sources served in priority order
	task automatic t_priority();
		wr_reg(ADR_MASK, 8'h0F);
		@(posedge clk_sys);
		rx_empty <= 1'b0;
		rx_done <= 1'b1;
		rx_full <= 1'b1;
		#1;
		chk({7'h0, rx_push}, 8'h00);
		@(posedge clk_sys);
		rx_done <= 1'b0;
		rx_full <= 1'b0;
		idle(3);
		chk({7'h0, intr}, 8'h01);
		rd_chk(ADR_IDENT, 8'h06);
		rd_chk(ADR_LSTAT, 8'h63);
		rd_chk(ADR_LSTAT, 8'h61);
		rd_chk(ADR_IDENT, 8'h04);
		@(posedge clk_sys);
		rx_empty <= 1'b1;
		rd_chk(ADR_IDENT, 8'h02);
		rd_chk(ADR_IDENT, 8'h01);
		@(posedge clk_sys);
		shift_empty <= 1'b0;
		rd_chk(ADR_LSTAT, 8'h20);
		@(posedge clk_sys);
		hold_empty <= 1'b0;
		rd_chk(ADR_LSTAT, 8'h00);
		@(posedge clk_sys);
		hold_empty <= 1'b1;
		shift_empty <= 1'b1;
		idle(3);
		rd_chk(ADR_IDENT, 8'h02);
		rd_chk(ADR_IDENT, 8'h01);
		wr_reg(ADR_MASK, 8'h00);
	endtask
	// Top-of-FIFO errors and the any-error flag in FIFO mode
	task automatic t_errors();
		@(posedge clk_sys);
		fifo_en <= 1'b1;
		rx_empty <= 1'b0;
		top_pe <= 1'b1;
		top_fe <= 1'b1;
		err_any <= 1'b1;
		rd_chk(ADR_LSTAT, 8'hED);
		rd_chk(ADR_IDENT, 8'hC1);
		wr_reg(ADR_MASK, 8'h01);
		rd_chk(ADR_IDENT, 8'hC1);
		@(posedge clk_sys);
		rx_tmo <= 1'b1;
		rd_chk(ADR_IDENT, 8'hCC);
		@(posedge clk_sys);
		rx_trig <= 1'b1;
		rd_chk(ADR_IDENT, 8'hC4);
		@(posedge clk_sys);
		rx_trig <= 1'b0;
		rx_tmo <= 1'b0;
		wr_reg(ADR_MASK, 8'h00);
		@(posedge clk_sys);
		rx_empty <= 1'b1;
		rd_chk(ADR_LSTAT, 8'hE0);
		@(posedge clk_sys);
		err_any <= 1'b0;
		rd_chk(ADR_LSTAT, 8'h60);
		@(posedge clk_sys);
		fifo_en <= 1'b0;
		top_pe <= 1'b0;
		top_fe <= 1'b0;
	endtask
	// Parity check on arrival; break stored once while the line is held low
	task automatic t_receive();
		wr_reg(ADR_MASK, 8'h04);
		wr_reg(ADR_LFC, 8'h4B);
		idle(4);
		@(posedge clk_sys);
		rx_data <= 8'h01;
		rx_par <= 1'b1;
		rx_done <= 1'b1;
		#1;
		chk({6'h0, rx_push, rx_push_pe}, 8'h03);
		@(posedge clk_sys);
		rx_par <= 1'b0;
		rx_brk <= 1'b1;
		#1;
		chk({6'h0, rx_push, rx_push_pe}, 8'h02);
		@(posedge clk_sys);
		#1;
		chk({7'h0, rx_push}, 8'h00);
		@(posedge clk_sys);
		rx_done <= 1'b0;
		rx_brk <= 1'b0;
		rd_chk(ADR_IDENT, 8'h06);
		wr_reg(ADR_LFC, 8'h00);
		wr_reg(ADR_MASK, 8'h00);
	endtask
	// Counts and verdict, then stop
	task automatic results();
		$display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (12) @(posedge clk_sys);
		rstn <= 1'b1;
		t_reset();
		t_format();
		t_break();
		t_divisor();
		t_modem_out();
		t_loop();
		t_modem_in();
		t_priority();
		t_receive();
		t_errors();
		results();
	end
	// Watchdog against a hang
	initial begin
		#(100 * 5000);
		fail_count++;
		results();
	end
endmodule // tb_uart_line_modem_status_control
`default_nettype wire
